// ==== inc/mdhc_pkg.sv ====
// Constants, register map and carrier types of the multichannel DAC host control block
package mdhc_pkg;
  localparam int NCH = 16;
  localparam int CW = 16;
  localparam int SCLK_MAX_MHZ = 50;
  localparam logic [6:0] REG_CTRL = 7'h00;
  localparam logic [6:0] REG_STAT = 7'h01;
  localparam logic [6:0] REG_SYNC = 7'h02;
  localparam logic [6:0] REG_TSEL0 = 7'h03;
  localparam logic [6:0] REG_TSEL1 = 7'h04;
  localparam logic [6:0] REG_DIFF = 7'h05;
  localparam logic [6:0] REG_RANGE0 = 7'h08;
  localparam logic [6:0] REG_OFS0 = 7'h0c;
  localparam logic [6:0] REG_CLRCODE = 7'h10;
  localparam logic [6:0] REG_DATA_A = 7'h20;
  localparam logic [6:0] REG_DATA_B = 7'h30;
  localparam logic [6:0] REG_NONE = 7'h7f;
  localparam int CTRL_SERIAL_OUT_ENABLE_BIT = 0;
  localparam int CTRL_EDGE = 1;
  localparam int CTRL_CRC = 2;
  localparam int CTRL_RUN = 3;
  localparam int STAT_CRC = 0;
  localparam int STAT_FRAME = 1;
  localparam logic [5:0] FRAME_BITS = 6'h18;
  localparam logic [5:0] FRAME_CRC_BITS = 6'h20;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] REG_RST = 16'h0000;
  // Order: reset_n, clear_n, load_n, dither[2:0], cs_n
  localparam logic [6:0] PIN_RST = 7'h71;

  typedef struct packed {
    logic grounded;
    logic diff;
    logic [3:0] range;
    logic [7:0] offset;
    logic [CW-1:0] code;
  } mdhc_chan_t;
endpackage

// ==== src/mdhc_top.sv ====
// Register file, serial port, pin synchronisers and channel update logic
//
// Implementation choices: register access over AHB-Lite and the register offsets.
module mdhc_top (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input logic sclk,
  input logic cs_n,
  input logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input logic dither_select_pin_0,
  input logic dither_select_pin_1,
  input logic dither_select_pin_2,
  input logic sync_load_strobe_n,
  input logic clear_outputs_n,
  input logic reset_pin_n,
  output logic alarm_out_n,
  output logic alarm_out_n_oe,
  output mdhc_pkg::mdhc_chan_t [mdhc_pkg::NCH-1:0] chan
);
  import mdhc_pkg::*;

  logic [6:0] pin_raw, s1_r, s2_r, s3_r, pin_r, ah_idx_r, wr_idx;
  logic soft_rst, core_rst_n, ah_wr_r, ah_rd_r, ah_acc, wr_en, spi_go, first_r;
  logic cs_hi_r, spi_pend_r, out_rise_r, out_fall_r, alarm_oe_r;
  logic [2:0] dither;
  logic [3:0] ctrl_r;
  logic [1:0] stat_r, stat_set, stat_clr;
  logic [15:0] sync_r, clr_code_r, wr_data;
  logic [31:0] tsel_r, sreg_r, resp_w;
  logic [7:0] diff_r;
  logic [63:0] range_r, ofs_r;
  logic [CW-1:0] a_r [NCH];
  logic [CW-1:0] b_r [NCH];
  logic [23:0] rd_hold_r, spi_cmd_r;
  logic [5:0] bit_cnt_r;
  mdhc_chan_t [NCH-1:0] chan_r;

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic [15:0] reg_read(input logic [6:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == REG_CTRL)
      v = {12'h000, ctrl_r};
    else if (idx == REG_STAT)
      v = {14'h0000, stat_r};
    else if (idx == REG_SYNC)
      v = sync_r;
    else if (idx == REG_TSEL0)
      v = tsel_r[15:0];
    else if (idx == REG_TSEL1)
      v = tsel_r[31:16];
    else if (idx == REG_DIFF)
      v = {8'h00, diff_r};
    else if (idx[6:2] == REG_RANGE0[6:2])
      v = range_r[16*idx[1:0] +: 16];
    else if (idx[6:2] == REG_OFS0[6:2])
      v = ofs_r[16*idx[1:0] +: 16];
    else if (idx == REG_CLRCODE)
      v = clr_code_r;
    else if (idx[6:4] == REG_DATA_A[6:4])
      v = a_r[idx[3:0]];
    else if (idx[6:4] == REG_DATA_B[6:4])
      v = b_r[idx[3:0]];
    return v;
  endfunction

  assign pin_raw = {reset_pin_n, clear_outputs_n, sync_load_strobe_n,
                    dither_select_pin_2, dither_select_pin_1, dither_select_pin_0, cs_n};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      pin_r <= PIN_RST;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts only once the second and third stages agree
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
    end
  end

  assign soft_rst = ~pin_r[6];
  // Built from a flop, so the derived reset leaves in step with hclk
  assign core_rst_n = hresetn & ~soft_rst;
  assign dither = pin_r[3:1];
  // link logic runs on sclk alone, so no ratio to hclk is assumed
  // Start flag: set while deselected, cleared by the first falling edge
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end
  // count only while selected; it keeps its value for the frame-end check
  always_ff @(negedge sclk or negedge hresetn)
  begin
    if (!hresetn)
      bit_cnt_r <= 6'h00;
    else if (!cs_n)
      bit_cnt_r <= first_r ? 6'h01 : bit_cnt_r + {5'h00, bit_cnt_r != 6'h3f};
  end
  // Read-back is quasi-static: it changes only between frames, long before the next sclk
  assign resp_w = {rd_hold_r, 8'h00};
  always_ff @(negedge sclk or negedge hresetn)
  begin
    if (!hresetn)
      sreg_r <= 32'h00000000;
    else if (!cs_n)
      sreg_r <= {first_r ? resp_w[30:0] : sreg_r[30:0], sdi};
  end
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      out_rise_r <= 1'b0;
    else
      out_rise_r <= first_r ? resp_w[31] : sreg_r[31];
  end
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      out_fall_r <= 1'b0;
    else
      out_fall_r <= first_r ? resp_w[30] : sreg_r[30];
  end
  // old bits fall out of sreg MSB, giving the daisy chain
  assign sdo = ctrl_r[CTRL_EDGE] ? (first_r ? resp_w[31] : out_fall_r) : out_rise_r;
  // driven only when enabled and selected
  assign sdo_oe = ctrl_r[CTRL_SERIAL_OUT_ENABLE_BIT] & ~cs_n;
  // Frame end: sclk is idle once chip select rises, so count and sreg are stable here
  always_ff @(posedge hclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      cs_hi_r <= 1'b1;
      spi_pend_r <= 1'b0;
      spi_cmd_r <= 24'h000000;
      stat_set <= 2'b00;
    end
    else
    begin
      cs_hi_r <= pin_r[0];
      stat_set <= 2'b00;
      if (pin_r[0] && !cs_hi_r)
      begin
        // CRC check on last 32 bits
        if (ctrl_r[CTRL_CRC])
        begin
          if (bit_cnt_r < FRAME_CRC_BITS)
            stat_set[STAT_FRAME] <= 1'b1;
          else if (crc8(sreg_r[31:8]) != sreg_r[7:0])
            stat_set[STAT_CRC] <= 1'b1;
          else
          begin
            spi_pend_r <= 1'b1;
            spi_cmd_r <= sreg_r[31:8];
          end
        end
        else if (bit_cnt_r < FRAME_BITS)
          stat_set[STAT_FRAME] <= 1'b1;
        else
        begin
          spi_pend_r <= 1'b1;
          spi_cmd_r <= sreg_r[23:0];
        end
      end
      else if (spi_go)
        spi_pend_r <= 1'b0;
    end
  end

  // A serial command waits one cycle behind a bus write so neither is lost
  assign spi_go = spi_pend_r & ~ah_wr_r;

  // AHB-Lite slave: writes take no wait state, reads one so hrdata comes from a flop
  assign ah_acc = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ah_wr_r <= 1'b0;
      ah_rd_r <= 1'b0;
      ah_idx_r <= REG_NONE;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end
    else
    begin
      ah_wr_r <= ah_acc & hwrite;
      ah_rd_r <= ah_acc & ~hwrite;
      if (ah_acc)
        ah_idx_r <= (haddr[31:9] == 23'h000000) ? haddr[8:2] : REG_NONE;
      hreadyout <= ~(ah_acc & ~hwrite);
      if (ah_rd_r)
        hrdata <= {16'h0000, reg_read(ah_idx_r)};
      hresp <= 1'b0;
    end
  end

  always_comb
  begin
    wr_en = 1'b0;
    wr_idx = REG_NONE;
    wr_data = 16'h0000;
    if (ah_wr_r)
    begin
      wr_en = 1'b1;
      wr_idx = ah_idx_r;
      wr_data = hwdata[15:0];
    end
    else if (spi_go && !spi_cmd_r[23])
    begin
      wr_en = 1'b1;
      wr_idx = spi_cmd_r[22:16];
      wr_data = spi_cmd_r[15:0];
    end
  end

  assign stat_clr = (wr_en && wr_idx == REG_STAT) ? wr_data[1:0] : 2'b00;

  // Status flags: set wins over a same-cycle write-one-to-clear
  always_ff @(posedge hclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      stat_r <= 2'b00;
    else
      stat_r <= (stat_r & ~stat_clr) | stat_set;
  end
  always_ff @(posedge hclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      rd_hold_r <= 24'h000000;
    else if (spi_go && spi_cmd_r[23])
      rd_hold_r <= {spi_cmd_r[23:16], reg_read(spi_cmd_r[22:16])};
  end
  // pin reset clears the same state
  always_ff @(posedge hclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      ctrl_r <= CTRL_RST;
      sync_r <= REG_RST;
      tsel_r <= {2{REG_RST}};
      diff_r <= REG_RST[7:0];
      range_r <= {4{REG_RST}};
      ofs_r <= {4{REG_RST}};
      clr_code_r <= REG_RST;
      for (int i = 0; i < NCH; i++)
      begin
        a_r[i] <= REG_RST;
        b_r[i] <= REG_RST;
      end
    end
    else if (wr_en)
    begin
      if (wr_idx == REG_CTRL)
        ctrl_r <= wr_data[3:0];
      else if (wr_idx == REG_SYNC)
        sync_r <= wr_data;
      else if (wr_idx == REG_TSEL0)
        tsel_r[15:0] <= wr_data;
      else if (wr_idx == REG_TSEL1)
        tsel_r[31:16] <= wr_data;
      else if (wr_idx == REG_DIFF)
        diff_r <= wr_data[7:0];
      else if (wr_idx[6:2] == REG_RANGE0[6:2])
        range_r[16*wr_idx[1:0] +: 16] <= wr_data;
      else if (wr_idx[6:2] == REG_OFS0[6:2])
        ofs_r[16*wr_idx[1:0] +: 16] <= wr_data;
      else if (wr_idx == REG_CLRCODE)
        clr_code_r <= wr_data;
      else if (wr_idx[6:4] == REG_DATA_A[6:4])
        a_r[wr_idx[3:0]] <= wr_data;
      else if (wr_idx[6:4] == REG_DATA_B[6:4])
        b_r[wr_idx[3:0]] <= wr_data;
    end
  end

  // Channel outputs; every channel is recomputed each cycle so updates land together
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NCH; ch++)
        chan_r[ch] <= '{grounded: 1'b1, diff: 1'b0, range: 4'h0, offset: 8'h00,
                        code: REG_RST};
    end
    else
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        chan_r[ch].range <= range_r[4*ch +: 4];
        chan_r[ch].diff <= diff_r[ch/2];
        chan_r[ch].offset <= ofs_r[8*(ch/2) +: 8];
        chan_r[ch].grounded <= ~ctrl_r[CTRL_RUN];
        if (!ctrl_r[CTRL_RUN])
          chan_r[ch].code <= REG_RST;
        else if (!pin_r[5])
          chan_r[ch].code <= clr_code_r;
        // synchronous channels wait for load low
        else if (!sync_r[ch] || !pin_r[4])
        begin
          // toggle pin picks A or B
          if (tsel_r[2*ch +: 2] != 2'b00 && dither[tsel_r[2*ch +: 2] - 2'b01])
            chan_r[ch].code <= b_r[ch];
          else
            chan_r[ch].code <= a_r[ch];
        end
      end
    end
  end

  assign chan = chan_r;

  // open drain: level stays low, only the enable moves
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alarm_out_n <= 1'b0;
      alarm_oe_r <= 1'b0;
    end
    else
    begin
      alarm_out_n <= 1'b0;
      alarm_oe_r <= |stat_r;
    end
  end

  assign alarm_out_n_oe = alarm_oe_r;
endmodule

// ==== bench/mdhc_props.sv ====
// Port checker for the DAC host control block
module mdhc_props import mdhc_pkg::*; (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic [31:0] hrdata,
  input logic hresp,
  input logic cs_n,
  input logic sdo_oe,
  input logic clear_outputs_n,
  input logic reset_pin_n,
  input logic alarm_out_n,
  input mdhc_pkg::mdhc_chan_t [mdhc_pkg::NCH-1:0] chan
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rq;
  assign rq = hsel && hready && htrans[1];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_oe;
    cs_n |-> !sdo_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("sdo driven outside frame");
  property p_alarm;
    !alarm_out_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm drives high");
  property p_resp;
    !hresp;
  endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
  property p_rd;
    rq && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  property p_wr;
    rq && hwrite |=> hreadyout;
  endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_rst;
    !reset_pin_n [*6] |=> chan[0].grounded && chan[15].grounded;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin left outputs live");
  property p_clr;
    !clear_outputs_n [*6] ##1 !chan[4].grounded |-> chan[4].code == chan[11].code;
  endproperty
  a_clr: assert property (p_clr) else $error("clear codes differ");
  property p_gnd;
    chan[5].grounded |-> chan[5].code == 16'h0000;
  endproperty
  a_gnd: assert property (p_gnd) else $error("grounded channel has code");
  property p_sync;
    $fell(clear_outputs_n) |=> $stable(chan[6].code);
  endproperty
  a_sync: assert property (p_sync) else $error("clear acted unsynchronised");
  c_rd: cover property (rq && !hwrite);
  c_clr: cover property (!clear_outputs_n [*6]);
  c_oe: cover property (sdo_oe);
endmodule

bind mdhc_top mdhc_props mdhc_props_i (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .cs_n, .sdo_oe, .clear_outputs_n,
  .reset_pin_n, .alarm_out_n, .chan);

// ==== bench/mdhc_host.sv ====
// Serial host model driving the link side of the block
module mdhc_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input logic sdo,
  input logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    // Raised after time zero so the block sees a real deselect edge
    #1;
    cs_n = 1'b1;
  end
  task automatic xfer(input logic [31:0] w, input int n, input logic fm,
                      output logic [31:0] r);
    r = 32'h0;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = w[i];
      #16;
      if (fm)
        r = {r[30:0], sdo_oe ? sdo : 1'bx};
      sclk = 1'b1;
      #32;
      if (!fm)
        r = {r[30:0], sdo_oe ? sdo : 1'bx};
      sclk = 1'b0;
      #16;
    end
    cs_n = 1'b1;
    // Released line shows no stale bit
    sdi = ~sdi;
    #250;
  endtask
endmodule

// ==== bench/test_multichannel_dac_host_control.sv ====
// Self-checking bench for the DAC host control block
module test_multichannel_dac_host_control import mdhc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, sclk, cs_n, sdi, sdo, sdo_oe, alm, alm_oe;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [2:0] dsel = 3'h0;
  logic load_n = 1'b1;
  logic clr_n = 1'b1;
  logic rpin_n = 1'b1;
  mdhc_chan_t [NCH-1:0] chan;
  int failures = 0;
  int checked = 0;
  assign hready = hreadyout;
  initial
    forever #12.5 hclk = ~hclk;
  mdhc_top mdhc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
    .dither_select_pin_0(dsel[0]), .dither_select_pin_1(dsel[1]),
    .dither_select_pin_2(dsel[2]), .sync_load_strobe_n(load_n),
    .clear_outputs_n(clr_n), .reset_pin_n(rpin_n), .alarm_out_n(alm),
    .alarm_out_n_oe(alm_oe), .chan);
  mdhc_host mdhc_host_i (.sclk, .cs_n, .sdi, .sdo, .sdo_oe);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1 && ++n < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1 && ++n < 40);
    q = hrdata;
    if (n >= 40)
    begin
      failures++;
      summarize();
    end
  endtask
  task automatic t_reg();
    logic [31:0] r;
    bus(0, 32'h0, 0);
    chk("ctrl reset", q, 32'h0);
    chk("grounded", chan[0].grounded, 1);
    mdhc_host_i.xfer(32'h007f0000, 32, 1'b0, r);
    chk("sdo idle", r, 32'hxxxxxxxx);
    bus(1, 32'h200, 32'hffff);
    bus(0, 32'h200, 0);
    chk("unmapped", q, 32'h0);
    $display("t_reg done");
  endtask
  task automatic t_spi();
    logic [31:0] r;
    logic [15:0] v;
    for (int fm = 0; fm < 2; fm++)
    begin
      v = 16'h1230 + fm;
      bus(1, 32'h0, 32'h9 | (fm << 1));
      mdhc_host_i.xfer({8'h22, v}, 24, fm[0], r);
      mdhc_host_i.xfer({8'ha2, 16'h0000}, 24, fm[0], r);
      mdhc_host_i.xfer(32'h007f0000, 32, fm[0], r);
      chk("readback", r, {8'ha2, v, 8'h00});
      bus(0, 32'h88, 0);
      chk("serial write", q, {16'h0000, v});
    end
    mdhc_host_i.xfer(24'h07f000, 20, 1'b1, r);
    bus(0, 32'h4, 0);
    chk("frame error", q, 32'h2);
    chk("alarm on", alm_oe, 1);
    bus(1, 32'h4, 32'h2);
    bus(0, 32'h4, 0);
    chk("alarm off", alm_oe, 0);
    $display("t_spi done");
  endtask
  task automatic t_tog();
    bus(1, 32'hc, 32'h39);
    for (int i = 0; i < 3; i++)
    begin
      bus(1, 32'h80 + 4 * i, 32'ha000 + i);
      bus(1, 32'hc0 + 4 * i, 32'hb000 + i);
    end
    for (int p = 0; p < 4; p++)
    begin
      dsel <= 3'h1 << p;
      repeat (8) @(posedge hclk);
      for (int c = 0; c < 3; c++)
        chk("toggle", chan[c].code, (c == p ? 32'hb000 : 32'ha000) + c);
    end
    $display("t_tog done");
  endtask
  task automatic t_cfg();
    bus(1, 32'h8, 32'h1);
    bus(1, 32'h80, 32'h1111);
    repeat (8) @(posedge hclk);
    chk("hold", chan[0].code, 32'ha000);
    load_n <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("load", chan[0].code, 32'h1111);
    load_n <= 1'b1;
    bus(1, 32'h20, 32'h0021);
    bus(1, 32'h14, 32'h1);
    bus(1, 32'h30, 32'h3300);
    repeat (2) @(posedge hclk);
    chk("range", {chan[1].range, chan[0].range}, 8'h21);
    chk("diff", {chan[2].diff, chan[1].diff}, 2'h1);
    chk("offset", chan[2].offset, 8'h33);
    bus(1, 32'h40, 32'h5a5a);
    clr_n <= 1'b0;
    repeat (8) @(posedge hclk);
    for (int c = 0; c < NCH; c++)
      chk("clear", chan[c].code, 32'h5a5a);
    clr_n <= 1'b1;
    rpin_n <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("pin reset", chan[0].grounded, 1);
    rpin_n <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(0, 32'h0, 0);
    chk("pin reset ctrl", q, 32'h0);
    $display("t_cfg done");
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reg();
    t_spi();
    t_tog();
    t_cfg();
    summarize();
  end
endmodule
